/* File: include/resolver_pkg.sv */
// Package with the constants shared by the resolver readout and its encoder emulation.
package resolver_pkg;

  // Synchroniser vector bit positions for the pins sampled by mclk_i.
  localparam int unsigned SYNC_W        = 6;
  localparam int unsigned SY_MODE_LOW   = 0;
  localparam int unsigned SY_MODE_HIGH  = 1;
  localparam int unsigned SY_SAMPLE     = 2;
  localparam int unsigned SY_SCLK       = 3;
  localparam int unsigned SY_SDI        = 4;
  localparam int unsigned SY_FSYNC      = 5;
  // Idle levels of the synchronised pins: frame sync, serial clock and sample strobe high.
  localparam logic [5:0]  SYNC_RST      = 6'h2C;

  // Frame sizes.
  localparam int unsigned FRAME_W       = 24;
  localparam int unsigned ANGLE_W       = 16;
  localparam int unsigned BYTE_W        = 8;

  // Serial register addresses, address bytes carry a set MSB.
  localparam logic [7:0]  ADDR_POS_HI   = 8'h80;
  localparam logic [7:0]  ADDR_POS_LO   = 8'h81;
  localparam logic [7:0]  ADDR_VEL_HI   = 8'h82;
  localparam logic [7:0]  ADDR_VEL_LO   = 8'h83;
  localparam logic [7:0]  ADDR_CTRL     = 8'h91;
  localparam logic [7:0]  ADDR_FAULT    = 8'hFF;
  localparam logic [7:0]  ADDR_RST      = 8'hFF;

  // Control register: D1..D0 digital resolution, D3..D2 encoder resolution.
  localparam int unsigned CTRL_DIG_LSB  = 0;
  localparam int unsigned CTRL_ENC_LSB  = 2;
  localparam logic [6:0]  CTRL_RST      = 7'h0F;

  // Fault bits: bit 7 is signal loss and drives both pins.
  localparam logic [7:0]  LOT_MASK      = 8'h8F;
  localparam logic [7:0]  DOS_MASK      = 8'hF0;
  localparam logic [7:0]  FAULT_RST     = 8'h80;

  // Local register port offsets.
  localparam logic [1:0]  OFS_CTRL      = 2'h0;
  localparam logic [1:0]  OFS_FAULT     = 2'h1;
  localparam logic [1:0]  OFS_STICKY    = 2'h2;

  // Encoder resolution codes 0..3 mean 10, 12, 14 and 16 bits.
  localparam int unsigned RES_BASE_BITS = 10;

  // Settling times after reset in ms, host side only, per resolution code.
  localparam int unsigned TRACK_MS_10   = 10;
  localparam int unsigned TRACK_MS_12   = 20;
  localparam int unsigned TRACK_MS_14   = 25;
  localparam int unsigned TRACK_MS_16   = 60;

  // Frame state of the serial port.
  typedef enum logic [1:0] {FR_IDLE, FR_NORMAL, FR_CONFIG} frame_e;

endpackage : resolver_pkg

/* File: include/enc_if.sv */
// Interface carrying position and resolution to the encoder emulation and its outputs back.
`timescale 1ns/100ps
interface enc_if;
  logic [15:0] position;   // Live integrator position.
  logic [1:0]  dig_res;    // Digital output resolution code.
  logic [1:0]  enc_res;    // Requested encoder resolution code.
  logic        enc_a;      // Quadrature A from a flop.
  logic        enc_b;      // Quadrature B from a flop.
  logic        marker;     // North marker from a flop.

  // Readout side drives position and resolution.
  modport src (output position, output dig_res, output enc_res, input enc_a, input enc_b, input marker);
  // Encoder side drives the quadrature outputs.
  modport enc (input position, input dig_res, input enc_res, output enc_a, output enc_b, output marker);
endinterface : enc_if

/* File: hw/quad_encoder_emul.sv */
// Incremental encoder emulation producing A, B and north marker from the live position.
`timescale 1ns/100ps
module quad_encoder_emul (
  input wire logic mclk_i,    // System clock.
  input wire logic resetn_i,  // Asynchronous reset, active low.
  enc_if.enc       enc        // Position in, quadrature out.
);
  import resolver_pkg::*;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  // Encoder resolution never exceeds the digital one.
  wire logic [1:0]  eff_res = (enc.enc_res > enc.dig_res) ? enc.dig_res : enc.enc_res;
  // Shift that drops the bits below the chosen resolution.
  wire logic [2:0]  drop    = 3'(6 - 2 * int'(eff_res));
  wire logic [15:0] pos_sh  = enc.position >> drop;
  logic a_q;          // Quadrature A.
  logic b_q;          // Quadrature B.
  logic nm_q;         // North marker.
  logic [1:0] prev_q; // Previous two low counts, for checking only.

  // A leads B on rising counts; marker spans the single zero count, a quarter A cycle.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      a_q    <= 1'b0;
      b_q    <= 1'b0;
      nm_q   <= 1'b0;
      prev_q <= 2'h0;
    end else begin
      a_q    <= pos_sh[1] ^ pos_sh[0];
      b_q    <= pos_sh[1];
      nm_q   <= (pos_sh == 16'h0000);
      prev_q <= pos_sh[1:0];
    end
  end

  assign enc.enc_a  = a_q;
  assign enc.enc_b  = b_q;
  assign enc.marker = nm_q;

  AST_ENC_LEAD: assert property ((prev_q == 2'h0) && (pos_sh[1:0] == 2'h1) |=> a_q && !b_q)
    else $error("A did not lead B on a rising count");
  AST_ENC_MARK: assert property (nm_q |-> !a_q && !b_q)
    else $error("North marker outside its quarter cycle");
  AST_ENC_OVR: assert property (eff_res <= enc.dig_res && eff_res <= enc.enc_res &&
                                (eff_res == enc.enc_res || eff_res == enc.dig_res))
    else $error("Encoder resolution not limited to digital resolution");

endmodule : quad_encoder_emul

/* File: hw/resolver_serial_readout.sv */
// Serial readout, fault latching and clearing, and encoder hookup of the resolver converter.
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/100ps
module resolver_serial_readout (
  input  wire logic                  mclk_i,                       // System clock, 25 MHz.
  input  wire logic                  resetn_i,                     // Asynchronous reset, active low.
  input  wire logic                  mode_select_low_i,            // Mode select, low bit, pin.
  input  wire logic                  mode_select_high_i,           // Mode select, high bit, pin.
  input  wire logic                  sample_n_i,                   // Sample strobe, active low, pin.
  input  wire logic                  sclk_i,                       // Serial clock, pin.
  input  wire logic                  sdi_i,                        // Serial data in, pin.
  input  wire logic                  write_frame_sync_n_i,         // Frame sync, active low, pin.
  input  wire logic [15:0]           position_i,                   // Position integrator, same clock.
  input  wire logic [15:0]           velocity_i,                   // Velocity integrator, same clock.
  input  wire logic [7:0]            fault_cond_i,                 // Live fault conditions, same clock.
  input  wire logic [1:0]            reg_addr_i,                   // Local register offset.
  input  wire logic [7:0]            reg_wdata_i,                  // Local register write data.
  input  wire logic                  reg_wr_i,                     // Local write strobe.
  input  wire logic                  reg_rd_i,                     // Local read strobe.
  output logic [7:0]                 reg_rdata_o,                  // Read data, cycle after strobe.
  output logic                       sdo_o,                        // Serial data out.
  output logic                       sdo_oe_n_o,                   // Serial out enable, low drives.
  output logic                       tracking_loss_flag_n_o,       // Tracking loss pin, active low.
  output logic                       signal_degradation_flag_n_o,  // Degradation pin, active low.
  output logic                       enc_a_o,                      // Quadrature A.
  output logic                       enc_b_o,                      // Quadrature B.
  output logic                       north_marker_o,               // North marker.
  output resolver_pkg::frame_e       frame_state_o                 // Serial port state, for debug.
);
  import resolver_pkg::*;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  // Pin synchronisers: first stage, second stage, and a third copy for edges.
  logic [SYNC_W-1:0] s1_q;  // First stage, read only by the second.
  logic [SYNC_W-1:0] s2_q;  // Second stage, safe to use.
  logic [SYNC_W-1:0] s3_q;  // Delayed copy for edge detection.

  // Holding and fault registers.
  logic [15:0] pos_hold_q;  // Sampled position.
  logic [15:0] vel_hold_q;  // Sampled velocity.
  logic [7:0]  fault_q;     // Fault register seen by the host.
  logic [7:0]  sticky_q;    // Latched faults driving the pins.
  logic        armed_q;     // Fault register was read, next sample clears.
  logic        lot_n_q;     // Tracking loss pin.
  logic        dos_n_q;     // Degradation pin.

  // Serial port state.
  frame_e      frame_q;     // Current frame kind.
  frame_e      frame_d;     // Next frame kind.
  logic [23:0] shift_q;     // Output shift register.
  logic [7:0]  in_q;        // Input shift register.
  logic [7:0]  addr_q;      // Last register address written.
  logic [6:0]  ctrl_q;      // Control register.
  logic [6:0]  ctrl_d;      // Next control value.
  logic [6:0]  wr_data_q;   // Data of the last serial write cycle.
  logic        oe_n_q;      // Output enable, low while framing.
  logic [7:0]  rdata_q;     // Local read data.

  // Synchronise every pin through two flops; the third flop only feeds edges.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
    end else begin
      s1_q <= {write_frame_sync_n_i,
               sdi_i,
               sclk_i,
               sample_n_i,
               mode_select_high_i,
               mode_select_low_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Edge decoding on the synchronised pins.
  wire logic sample_fall = s3_q[SY_SAMPLE] & ~s2_q[SY_SAMPLE];
  wire logic sclk_rise   = ~s3_q[SY_SCLK] & s2_q[SY_SCLK];
  wire logic sclk_fall   = s3_q[SY_SCLK] & ~s2_q[SY_SCLK];
  wire logic fs_fall     = s3_q[SY_FSYNC] & ~s2_q[SY_FSYNC];
  wire logic fs_rise     = ~s3_q[SY_FSYNC] & s2_q[SY_FSYNC];
  wire logic cfg_mode    = s2_q[SY_MODE_LOW] & s2_q[SY_MODE_HIGH];
  wire logic sdi_s       = s2_q[SY_SDI];

  // Fault update: new conditions always accumulate, so a set beats a clear.
  wire logic       clear_now = sample_fall & armed_q;
  wire logic [7:0] sticky_d  = clear_now ? fault_cond_i : (sticky_q | fault_cond_i);

  // Sample strobe copies the integrators and refreshes the fault register.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pos_hold_q <= 16'h0000;
      vel_hold_q <= 16'h0000;
      fault_q    <= FAULT_RST;
    end else if (sample_fall) begin
      pos_hold_q <= position_i;
      vel_hold_q <= velocity_i;
      fault_q    <= sticky_q | fault_cond_i;
    end
  end

  // Latched faults drive the two pins; reset shows signal loss on both.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sticky_q <= FAULT_RST;
      lot_n_q  <= 1'b0;
      dos_n_q  <= 1'b0;
    end else begin
      sticky_q <= sticky_d;
      lot_n_q  <= ~|(sticky_q & LOT_MASK);
      dos_n_q  <= ~|(sticky_q & DOS_MASK);
    end
  end

  // A data frame ended while the fault address was selected: the fault register was read.
  wire logic cfg_end    = fs_rise & (frame_q == FR_CONFIG);
  wire logic fault_read = cfg_end & ~in_q[7] & (addr_q == ADDR_FAULT);

  // Clear is armed by the fault read and consumed by the following sample edge.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      armed_q <= 1'b0;
    end else if (fault_read) begin
      armed_q <= 1'b1;
    end else if (clear_now) begin
      armed_q <= 1'b0;
    end
  end

  // Frame kind follows frame sync and the mode selects at the frame's start.
  always_comb begin
    frame_d = frame_q;
    case (frame_q)
      FR_IDLE: begin
        if (fs_fall) begin
          frame_d = cfg_mode ? FR_CONFIG : FR_NORMAL;
        end
      end
      FR_NORMAL, FR_CONFIG: begin
        if (fs_rise) begin
          frame_d = FR_IDLE;
        end
      end
      default: begin
        frame_d = FR_IDLE;
      end
    endcase
  end

  // Angle chosen by the low mode select in normal mode.
  wire logic [15:0] angle_word = s2_q[SY_MODE_LOW] ? vel_hold_q : pos_hold_q;
  // Readback of the control register flags a mismatch with the data of the last serial write.
  wire logic        ctrl_err   = (ctrl_q != wr_data_q);
  // Byte selected by the last address for configuration reads.
  wire logic [7:0]  cfg_byte   = (addr_q == ADDR_POS_HI) ? pos_hold_q[15:8] :
                                 (addr_q == ADDR_POS_LO) ? pos_hold_q[7:0]  :
                                 (addr_q == ADDR_VEL_HI) ? vel_hold_q[15:8] :
                                 (addr_q == ADDR_VEL_LO) ? vel_hold_q[7:0]  :
                                 (addr_q == ADDR_CTRL)   ? {ctrl_err, ctrl_q} :
                                 (addr_q == ADDR_FAULT)  ? fault_q          : 8'h00;
  // Word loaded at the start of a frame: eight bits in config, 24 in normal mode.
  wire logic [23:0] frame_word = cfg_mode ? {cfg_byte, 16'h0000} : {angle_word, fault_q};
  wire logic        active     = (frame_q != FR_IDLE);

  // Output shift register: loaded on frame start, advanced on serial clock rising edges.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shift_q <= 24'h00_0000;
      oe_n_q  <= 1'b1;
      frame_q <= FR_IDLE;
    end else begin
      frame_q <= frame_d;
      oe_n_q  <= s2_q[SY_FSYNC];
      if (fs_fall && frame_q == FR_IDLE) begin
        shift_q <= frame_word;
      end else if (sclk_rise && active) begin
        shift_q <= {shift_q[22:0], 1'b0};
      end
    end
  end

  // Input shift register samples on serial clock falling edges during config frames.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_q <= 8'h00;
    end else if (fs_fall) begin
      in_q <= 8'h00;
    end else if (sclk_fall && frame_q == FR_CONFIG) begin
      in_q <= {in_q[6:0], sdi_s};
    end
  end

  // Serial writes take priority over local writes of the control register.
  wire logic ser_wr  = cfg_end & ~in_q[7];
  wire logic loc_wr  = reg_wr_i & (reg_addr_i == OFS_CTRL);
  assign ctrl_d = (ser_wr && addr_q == ADDR_CTRL) ? in_q[6:0] :
                  loc_wr                          ? reg_wdata_i[6:0] : ctrl_q;

  // Byte latched at frame end: set MSB is an address, clear MSB is data.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_q    <= ADDR_RST;
      ctrl_q    <= CTRL_RST;
      wr_data_q <= CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
      if (cfg_end && in_q[7]) begin
        addr_q <= in_q;
      end
      if (ser_wr) begin
        wr_data_q <= in_q[6:0];
      end
    end
  end

  // Local read port: data only in the cycle after the strobe.
  wire logic [7:0] loc_mux = (reg_addr_i == OFS_CTRL)   ? {1'b0, ctrl_q} :
                             (reg_addr_i == OFS_FAULT)  ? fault_q :
                             (reg_addr_i == OFS_STICKY) ? sticky_q : 8'h00;

  // Read data are zero outside the cycle after a read strobe.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd_i ? loc_mux : 8'h00;
    end
  end

  // Encoder emulation runs from the live position regardless of the host.
  enc_if enc_bus ();
  assign enc_bus.position = position_i;
  assign enc_bus.dig_res  = ctrl_q[CTRL_DIG_LSB +: 2];
  assign enc_bus.enc_res  = ctrl_q[CTRL_ENC_LSB +: 2];

  quad_encoder_emul u_enc (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .enc      (enc_bus)
  );

  // Outputs straight from flops.
  assign reg_rdata_o                 = rdata_q;
  assign sdo_o                       = shift_q[FRAME_W-1];
  assign sdo_oe_n_o                  = oe_n_q;
  assign tracking_loss_flag_n_o      = lot_n_q;
  assign signal_degradation_flag_n_o = dos_n_q;
  assign enc_a_o                     = enc_bus.enc_a;
  assign enc_b_o                     = enc_bus.enc_b;
  assign north_marker_o              = enc_bus.marker;
  assign frame_state_o               = frame_q;

  // Sample edge refreshes both holds.
  AST_SAMPLE_COPY: assert property (sample_fall |=> pos_hold_q == $past(position_i) &&
                                    vel_hold_q == $past(velocity_i))
    else $error("Holding registers not refreshed on sample edge");

  // Sample edge refreshes the faults.
  AST_FAULT_COPY: assert property (sample_fall |=> fault_q == ($past(sticky_q) | $past(fault_cond_i)))
    else $error("Fault register not refreshed on sample edge");

  // Normal frame loads angle and fault.
  AST_NORMAL_LOAD: assert property (fs_fall && !cfg_mode && frame_q == FR_IDLE
                                    |=> shift_q == {$past(angle_word), $past(fault_q)})
    else $error("Normal frame not loaded with angle and fault");

  // Config frame loads one byte.
  AST_CFG_LOAD: assert property (fs_fall && cfg_mode && frame_q == FR_IDLE
                                 |=> shift_q[15:0] == 16'h0000 && shift_q[23:16] == $past(cfg_byte))
    else $error("Config frame not eight bits");

  // Output holds between rises.
  AST_SDO_HOLD: assert property (!sclk_rise && !fs_fall |=> $stable(shift_q))
    else $error("Serial output changed without a rising serial clock");

  // Each rise moves one bit.
  AST_SHIFT_STEP: assert property (sclk_rise && active |=> shift_q == {$past(shift_q[22:0]), 1'b0})
    else $error("Serial output did not advance one bit");

  // Each fall takes one bit.
  AST_SDI_TAKE: assert property (sclk_fall && frame_q == FR_CONFIG && !fs_fall |=> in_q[0] == $past(sdi_s))
    else $error("Serial input not sampled on falling edge");

  // Frame start enables output.
  AST_OE_FOLLOW: assert property (fs_fall |=> ##1 !oe_n_q)
    else $error("Output not enabled after frame sync fell");

  // Frame end releases output.
  AST_OE_RELEASE: assert property (fs_rise |=> oe_n_q)
    else $error("Output not released after frame sync rose");

  // Latched faults pull the loss pin.
  AST_PIN_LOW: assert property ((sticky_q & LOT_MASK) != 8'h00 |=> !lot_n_q)
    else $error("Tracking loss pin not low with a latched fault");

  // Latched faults pull the degradation pin.
  AST_DOS_LOW: assert property ((sticky_q & DOS_MASK) != 8'h00 |=> !dos_n_q)
    else $error("Degradation pin not low with a latched fault");

  // Clear with no live fault frees pins.
  AST_CLEAR: assert property (clear_now && fault_cond_i == 8'h00 |=>
                              sticky_q == 8'h00 ##1 lot_n_q && dos_n_q)
    else $error("Second sample edge did not release the fault pins");

  // A fault read arms the clear.
  AST_ARM: assert property (fault_read |=> armed_q)
    else $error("Fault read did not arm the clear");

  // Serial control write reads back clean.
  AST_ERR_FLAG: assert property (ser_wr && addr_q == ADDR_CTRL |=> !cfg_byte[7])
    else $error("Control readback flagged after a matching write");

  // Differing local write raises the flag.
  AST_ERR_SET: assert property (loc_wr && !ser_wr && reg_wdata_i[6:0] != wr_data_q
                                |=> ctrl_err)
    else $error("Control readback not flagged after a differing write");

endmodule : resolver_serial_readout

/* File: verif/host_serial_model.sv */
// Host serial port model that frames, clocks and samples the readout link.
`timescale 1ns/100ps
module host_serial_model (
  input  wire logic mclk_i,               // System clock, paces the link.
  input  wire logic sdo_i,                // Serial data from the device.
  input  wire logic sdo_oe_n_i,           // Device output enable, low drives.
  output logic      sclk_o,               // Serial clock, stands high outside frames.
  output logic      sdi_o,                // Serial data to the device.
  output logic      write_frame_sync_n_o  // Frame sync, active low.
);
  initial begin
    sclk_o = 1'b1;
    sdi_o = 1'b0;
    write_frame_sync_n_o = 1'b1;
  end
  // One frame of n bits, MSB first; the link half period is four mclk cycles.
  task automatic frame(input int n, input logic [23:0] din, output logic [23:0] dout);
    dout = 24'h00_0000;
    write_frame_sync_n_o <= 1'b0;
    repeat (8) @(posedge mclk_i);
    for (int i = 0; i < n; i++) begin
      sdi_o <= din[n-1-i];
      repeat (4) @(posedge mclk_i);
      sclk_o <= 1'b0;
      repeat (4) @(posedge mclk_i);
      // A released line reads as the inverse of its last level.
      dout = {dout[22:0], sdo_oe_n_i ? ~sdo_i : sdo_i};
      sclk_o <= 1'b1;
    end
    repeat (4) @(posedge mclk_i);
    write_frame_sync_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    repeat (8) @(posedge mclk_i);
  endtask : frame
endmodule : host_serial_model

/* File: verif/test_resolver_serial_readout_encoder.sv */
// Self-checking bench for the resolver serial readout and encoder emulation.
`timescale 1ns/100ps
module test_resolver_serial_readout_encoder;
  import resolver_pkg::*;
  logic        mclk_i, resetn_i, mode_select_low_i, mode_select_high_i, sample_n_i;  // Clock, reset, pins.
  logic        sclk_i, sdi_i, write_frame_sync_n_i, reg_wr_i, reg_rd_i;             // Link and strobes.
  logic [15:0] position_i, velocity_i;                                               // Integrator values.
  logic [7:0]  fault_cond_i, reg_wdata_i, reg_rdata_o;                               // Faults, local port.
  logic [1:0]  reg_addr_i;                                                           // Local offset.
  logic        sdo_o, sdo_oe_n_o, tracking_loss_flag_n_o, signal_degradation_flag_n_o; // Serial, faults.
  logic        enc_a_o, enc_b_o, north_marker_o;                                     // Encoder outputs.
  frame_e      frame_state_o;                                                        // Debug state.
  logic [23:0] rx;                                                                   // Last frame read.
  int          miscompares, cmp_count;                                               // Counters.
  typedef struct {logic l; logic [15:0] p, v, e;} row_s;
  typedef struct {logic [7:0] c; logic [15:0] p; logic [2:0] o;} erow_s;
  // Normal frames: select, position, velocity, expected angle word.
  row_s rows[4] = '{'{0, 16'hFFFF, 16'h0001, 16'hFFFF}, '{1, 16'h0002, 16'h7FFF, 16'h7FFF},
                    '{0, 16'h0000, 16'h1234, 16'h0000}, '{1, 16'h5555, 16'h8000, 16'h8000}};
  // Encoder: control, position, expected {A, B, marker}.
  erow_s erows[8] = '{'{8'h03, 16'h0040, 3'b100}, '{8'h07, 16'h0010, 3'b100}, '{8'h0B, 16'h0004, 3'b100},
                      '{8'h0F, 16'h0001, 3'b100}, '{8'h07, 16'h0020, 3'b110}, '{8'h07, 16'h0030, 3'b010},
                      '{8'h07, 16'h0000, 3'b001}, '{8'h0C, 16'h0001, 3'b001}};
  resolver_serial_readout u_resolver_serial_readout (.mclk_i, .resetn_i, .mode_select_low_i,
    .mode_select_high_i, .sample_n_i, .sclk_i, .sdi_i, .write_frame_sync_n_i, .position_i, .velocity_i,
    .fault_cond_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sdo_o, .sdo_oe_n_o,
    .tracking_loss_flag_n_o, .signal_degradation_flag_n_o, .enc_a_o, .enc_b_o, .north_marker_o,
    .frame_state_o);
  host_serial_model u_host_serial_model (.mclk_i(mclk_i), .sdo_i(sdo_o), .sclk_o(sclk_i), .sdi_o(sdi_i),
    .sdo_oe_n_i(sdo_oe_n_o), .write_frame_sync_n_o(write_frame_sync_n_i));
  // Free running 25 MHz clock.
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : cyc
  // Sample strobe low long enough for the synchroniser, then high again.
  task automatic pulse_sample();
    sample_n_i <= 1'b0;
    cyc(6);
    sample_n_i <= 1'b1;
    cyc(6);
  endtask : pulse_sample
  task automatic mode(input logic h, input logic l);
    mode_select_high_i <= h;
    mode_select_low_i <= l;
    cyc(4);
  endtask : mode
  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    cyc(1);
    reg_wr_i <= 1'b0;
  endtask : reg_write
  // Read data stand only in the cycle after the strobe.
  task automatic reg_read(input logic [1:0] a, input logic [7:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    cyc(1);
    reg_rd_i <= 1'b0;
    #1;
    chk("local read", e, reg_rdata_o);
    cyc(1);
  endtask : reg_read
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // Watchdog: a hang counts as a mismatch.
  initial begin
    #1_000_000;
    miscompares++;
    stop_test();
  end
  initial begin
    {resetn_i, mode_select_low_i, mode_select_high_i, reg_wr_i, reg_rd_i} = 5'h00;
    sample_n_i = 1'b1;
    {position_i, velocity_i, fault_cond_i, reg_wdata_i, reg_addr_i} = 50'h0;
    miscompares = 0;
    cmp_count = 0;
    cyc(2);
    chk("pins in reset", 5'h04, {tracking_loss_flag_n_o, signal_degradation_flag_n_o, sdo_oe_n_o,
        enc_a_o, enc_b_o});
    resetn_i <= 1'b1;
    cyc(2);
    foreach (rows[i]) begin
      mode(1'b0, rows[i].l);
      position_i <= rows[i].p;
      velocity_i <= rows[i].v;
      cyc(2);
      pulse_sample();
      position_i <= ~rows[i].p;
      velocity_i <= ~rows[i].v;
      u_host_serial_model.frame(24, 24'h00_0000, rx);
      chk("angle word", rows[i].e, rx[23:8]);
      chk("fault byte", FAULT_RST, rx[7:0]);
    end
    u_host_serial_model.frame(16, 24'h00_0000, rx);
    chk("short frame", rows[3].e, rx[15:0]);
    chk("released", 1'b1, sdo_oe_n_o);
    chk("frame state", FR_IDLE, frame_state_o);
    $display("normal frame tests done");
    mode(1'b1, 1'b1);
    u_host_serial_model.frame(8, {16'h0000, ADDR_FAULT}, rx);
    u_host_serial_model.frame(8, 24'h00_0000, rx);
    chk("fault register", FAULT_RST, rx[7:0]);
    pulse_sample();
    chk("pins cleared", 2'b11, {tracking_loss_flag_n_o, signal_degradation_flag_n_o});
    fault_cond_i <= 8'h01;
    cyc(4);
    chk("tracking fault", 2'b01, {tracking_loss_flag_n_o, signal_degradation_flag_n_o});
    fault_cond_i <= 8'h10;
    u_host_serial_model.frame(8, 24'h00_0000, rx);
    pulse_sample();
    chk("persistent fault", 2'b10, {tracking_loss_flag_n_o, signal_degradation_flag_n_o});
    $display("fault clear tests done");
    position_i <= 16'h3C5A;
    velocity_i <= 16'h0081;
    pulse_sample();
    u_host_serial_model.frame(8, {16'h0000, ADDR_POS_HI}, rx);
    u_host_serial_model.frame(8, {16'h0000, ADDR_VEL_LO}, rx);
    chk("config position", 8'h3C, rx[7:0]);
    u_host_serial_model.frame(8, {16'h0000, ADDR_CTRL}, rx);
    chk("config velocity", 8'h81, rx[7:0]);
    u_host_serial_model.frame(8, 24'h00_0005, rx);
    u_host_serial_model.frame(8, {16'h0000, ADDR_CTRL}, rx);
    chk("control readback", 8'h05, rx[7:0]);
    reg_write(OFS_CTRL, 8'h07);
    u_host_serial_model.frame(8, {16'h0000, ADDR_CTRL}, rx);
    chk("control error bit", 8'h87, rx[7:0]);
    reg_read(OFS_CTRL, 8'h07);
    reg_read(OFS_FAULT, 8'h10);
    reg_read(OFS_STICKY, 8'h10);
    reg_read(2'h3, 8'h00);
    $display("register tests done");
    foreach (erows[i]) begin
      reg_write(OFS_CTRL, erows[i].c);
      position_i <= erows[i].p;
      cyc(6);
      chk("encoder outputs", erows[i].o, {enc_a_o, enc_b_o, north_marker_o});
    end
    $display("encoder tests done");
    resetn_i <= 1'b0;
    cyc(250);
    chk("pins in second reset", 5'h00, {tracking_loss_flag_n_o, signal_degradation_flag_n_o, enc_a_o, enc_b_o,
        north_marker_o});
    resetn_i <= 1'b1;
    cyc(2);
    chk("encoder after reset", 3'b100, {enc_a_o, enc_b_o, north_marker_o});
    cyc(2);
    $display("reset tests done");
    stop_test();
  end
endmodule : test_resolver_serial_readout_encoder
